// ### pmt_pkg.sv
/*
 * pmt_pkg: constants for the program memory and table-read unit.
 * assumes: used by pmt_top and pmt_ser; nothing imported.
 */
package pmt_pkg;
    // ********************************
    // store geometry
    // ********************************
    localparam int          PM_DEPTH     = 1024;
    localparam int          PM_AW        = 10;
    localparam int          PM_DW        = 14;
    localparam int          LOW_W        = 8;
    localparam int          HIGH_W       = 6;
    localparam logic [9:0]  RESET_VECTOR = 10'h000;
    localparam logic [9:0]  LAST_PAGE    = 10'h300;
    // ********************************
    // serial programming frame
    // ********************************
    localparam int          SER_CMD_W    = 2;
    localparam int          SER_FRAME_W  = 26;
    localparam logic [1:0]  SER_CMD_WR   = 2'h1;
    localparam logic [1:0]  SER_CMD_RD   = 2'h2;
    localparam logic [4:0]  SER_RD_BITS  = 5'h0E;
    // ********************************
    // sequencer states
    // ********************************
    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_TABLE = 2'b01,
        ST_DUMMY = 2'b10
    } pmt_state_e;
endpackage

// ### pmt_ser_if.sv
/*
 * pmt_ser_if: carries store write and read requests between the serial
 * programming port and the main unit.
 * assumes: one clock domain, top unit owns the store.
 */
`timescale 1ns/1ps
interface pmt_ser_if;
    logic             wr_en;
    logic [9:0]       addr;
    logic [13:0]      wdata;
    logic [13:0]      rdata;
    logic             active;
    modport port (output wr_en, output addr, output wdata, output active, input rdata);
    modport core (input wr_en, input addr, input wdata, input active, output rdata);
endinterface

// ### pmt_ser.sv
/*
 * pmt_ser: serial programming port on one shared data line and a clock
 * line from the programmer.
 * assumes: pins already synchronous to the system clock; frame is
 * 2 command bits, 10 address bits, 14 data bits, msb first, on rising edges.
 */
`timescale 1ns/1ps
module pmt_ser (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // programmer pins
    input  wire logic   sclk,
    input  wire logic   sda_in,
    output logic        sda_out,
    output logic        sda_oe,
    // store side
    pmt_ser_if.port     mem
);
    logic        sclk_q, sclk_d;
    logic [25:0] sh_q, sh_d;
    logic [4:0]  cnt_q, cnt_d;
    logic        rd_q, rd_d;
    logic [13:0] out_q, out_d;
    logic        wr_q, wr_d;
    logic        rise;

    assign rise = sclk & ~sclk_q;

    always_comb begin
        sclk_d = sclk;
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        rd_d   = rd_q;
        out_d  = out_q;
        wr_d   = 1'b0;
        if (rise) begin
            if (rd_q) begin
                // read-back shifts the word out, device drives the line
                out_d = {out_q[12:0], 1'b0};
                cnt_d = cnt_q - 5'h01;
                if (cnt_q == 5'h01) begin
                    rd_d = 1'b0;
                end
            end else begin
                sh_d  = {sh_q[24:0], sda_in};
                cnt_d = cnt_q + 5'h01;
                if (cnt_q == 5'(pmt_pkg::SER_CMD_W + pmt_pkg::PM_AW - 1)
                    && sh_q[10:9] == pmt_pkg::SER_CMD_RD) begin
                    rd_d  = 1'b1;
                    cnt_d = pmt_pkg::SER_RD_BITS;
                    out_d = mem.rdata;
                end else if (cnt_q == 5'(pmt_pkg::SER_FRAME_W - 1)) begin
                    cnt_d = 5'h00;
                    wr_d  = (sh_q[24:23] == pmt_pkg::SER_CMD_WR);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            sh_q   <= 26'h0000000;
            cnt_q  <= 5'h00;
            rd_q   <= 1'b0;
            out_q  <= 14'h0000;
            wr_q   <= 1'b0;
        end else begin
            sclk_q <= sclk_d;
            sh_q   <= sh_d;
            cnt_q  <= cnt_d;
            rd_q   <= rd_d;
            out_q  <= out_d;
            wr_q   <= wr_d;
        end
    end

    assign mem.wr_en  = wr_q;
    // a read takes its word on the last address bit, still on the line
    assign mem.addr   = (!rd_q && cnt_q == 5'(pmt_pkg::SER_CMD_W + pmt_pkg::PM_AW - 1))
                        ? {sh_q[8:0], sda_in} : sh_q[23:14];
    assign mem.wdata  = sh_q[13:0];
    assign mem.active = (cnt_q != 5'h00) | rd_q;
    assign sda_out    = out_q[13];
    assign sda_oe     = rd_q;
endmodule

// ### pmt_top.sv
/*
 * pmt_top: program store, program counter and table-read unit.
 * assumes: the cpu gives one-cycle instruction strobes synchronous to
 * REF_CLK; one REF_CLK edge is one instruction cycle here.
 * the store keeps its contents through reset and is written only by the
 * serial port; the cpu stalls for as long as a frame is in flight.
 * limitation: every table read shares the holding register, so software
 * must keep interrupt handlers away from table reads in the meantime.
 * fetch takes one word per cycle; a jump or a pc low byte write costs
 * one dummy cycle before the new word is fetched.
 */
// How it works
// [R1] store holds 1024 words of 14 bits
// [R2] reset puts pc at word zero
// [R3] table reads addressed by the table pointer
// [R4] low byte goes to operand register
// [R5] upper bits go to holding, rest zero
// [R6] page variant offsets pointer within pc page
// [R7] table instructions take two cycles
// [R8] software guards shared holding register from interrupts
// [R9] serial data line shared, programmer clocks
// [R10] ten-bit pc, low byte write jumps in page
// [R11] fetch suppressed during table access cycle
`timescale 1ns/1ps
module pmt_top (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_B,
    // cpu control
    input  wire logic        TBL_RD_ANY,
    input  wire logic        TBL_RD_PAGE,
    input  wire logic [7:0]  TBL_DEST,
    input  wire logic [9:0]  TBL_PTR,
    input  wire logic        PC_LOW_WR,
    input  wire logic [7:0]  PC_LOW_WDATA,
    input  wire logic        JUMP,
    input  wire logic [9:0]  JUMP_ADDR,
    // fetch and table results
    output logic [9:0]       PC,
    output logic [13:0]      INSTR,
    output logic             INSTR_VALID,
    output logic [7:0]       PC_LOW_BYTE,
    output logic             TBL_WR,
    output logic [7:0]       TBL_WR_ADDR,
    output logic [7:0]       TBL_WR_DATA,
    output logic [7:0]       TABLE_HIGH_HOLDING,
    // programming pins
    input  wire logic        PROG_SERIAL_CLOCK_LINE,
    input  wire logic        PROG_SERIAL_DATA_LINE_IN,
    output logic             PROG_SERIAL_DATA_LINE_OUT,
    output logic             PROG_SERIAL_DATA_LINE_OE
);
    // ********************************
    // reset release
    // ********************************
    logic rst_s1_q, rst_n_q;
    // release goes through two flops so no flop leaves reset on a ragged edge
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ********************************
    // program store
    // ********************************
    // [R1] store array
    logic [13:0] mem [0:pmt_pkg::PM_DEPTH-1];
    logic [9:0]  rd_addr;
    logic [13:0] rd_word;
    pmt_ser_if   ser();

    // the port reads the store at the address it has just assembled,
    // so a read frame needs no wait state
    // [R9] serial port
    pmt_ser u_ser (
        .clk     (REF_CLK),
        .rst_n   (rst_n_q),
        .sclk    (PROG_SERIAL_CLOCK_LINE),
        .sda_in  (PROG_SERIAL_DATA_LINE_IN),
        .sda_out (PROG_SERIAL_DATA_LINE_OUT),
        .sda_oe  (PROG_SERIAL_DATA_LINE_OE),
        .mem     (ser.port)
    );

    // store has no reset: its contents stand for the flash array
    always_ff @(posedge REF_CLK) begin
        if (ser.wr_en) begin
            mem[ser.addr] <= ser.wdata;
        end
    end
    assign rd_word   = mem[rd_addr];
    assign ser.rdata = mem[ser.addr];

    // ********************************
    // sequencer
    // ********************************
    pmt_pkg::pmt_state_e st_q, st_d;
    logic [9:0]  pc_q, pc_d;
    logic [9:0]  tp_q, tp_d;
    logic [7:0]  dst_q, dst_d;
    logic [13:0] ins_q, ins_d;
    logic        iv_q, iv_d;
    logic        tw_q, tw_d;
    logic [7:0]  tdat_q, tdat_d;
    logic [7:0]  thi_q, thi_d;

    // ********************************
    // store read port
    // ********************************
    // one read port serves both fetch and table access; the table cycle
    // borrows it instead of a second port on the store, which is why
    // the fetch pauses for that cycle
    // [R11] table access owns port
    always_comb begin
        rd_addr = pc_q;
        if (st_q == pmt_pkg::ST_TABLE) begin
            rd_addr = tp_q;
        end
    end

    always_comb begin
        st_d   = st_q;
        pc_d   = pc_q;
        tp_d   = tp_q;
        dst_d  = dst_q;
        ins_d  = ins_q;
        iv_d   = 1'b0;
        tw_d   = 1'b0;
        tdat_d = tdat_q;
        thi_d  = thi_q;
        if (ser.active) begin
            // programming owns the store; cpu stalls
            st_d = pmt_pkg::ST_FETCH;
        end else begin
            case (st_q)
                pmt_pkg::ST_FETCH: begin
                    // a table read wins over a pc write, which wins over a jump
                    if (TBL_RD_ANY || TBL_RD_PAGE) begin
                        // [R3] pointer address
                        tp_d = TBL_PTR;
                        // [R6] page relative
                        if (TBL_RD_PAGE) begin
                            tp_d = {pc_q[9:8], TBL_PTR[7:0]};
                        end
                        dst_d = TBL_DEST;
                        // [R7] second cycle
                        st_d  = pmt_pkg::ST_TABLE;
                    end else if (PC_LOW_WR) begin
                        // [R10] in-page jump
                        pc_d = {pc_q[9:8], PC_LOW_WDATA};
                        st_d = pmt_pkg::ST_DUMMY;
                    end else if (JUMP) begin
                        pc_d = JUMP_ADDR;
                        st_d = pmt_pkg::ST_DUMMY;
                    end else begin
                        ins_d = rd_word;
                        iv_d  = 1'b1;
                        pc_d  = pc_q + 10'h001;
                    end
                end
                pmt_pkg::ST_TABLE: begin
                    // [R4] low byte
                    tw_d   = 1'b1;
                    tdat_d = rd_word[7:0];
                    // [R5] upper bits
                    thi_d  = {2'h0, rd_word[13:8]};
                    st_d   = pmt_pkg::ST_FETCH;
                end
                pmt_pkg::ST_DUMMY: begin
                    // stands in for the prefetched word that the jump throws away
                    st_d = pmt_pkg::ST_FETCH;
                end
                default: begin
                    st_d = pmt_pkg::ST_FETCH;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q   <= pmt_pkg::ST_FETCH;
            // [R2] reset vector
            pc_q   <= pmt_pkg::RESET_VECTOR;
            tp_q   <= 10'h000;
            dst_q  <= 8'h00;
            ins_q  <= 14'h0000;
            iv_q   <= 1'b0;
            tw_q   <= 1'b0;
            tdat_q <= 8'h00;
            thi_q  <= 8'h00;
        end else begin
            st_q   <= st_d;
            pc_q   <= pc_d;
            tp_q   <= tp_d;
            dst_q  <= dst_d;
            ins_q  <= ins_d;
            iv_q   <= iv_d;
            tw_q   <= tw_d;
            tdat_q <= tdat_d;
            thi_q  <= thi_d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    // straight register copies, so no path from an input reaches a pin
    // within the same cycle
    assign PC                 = pc_q;
    assign PC_LOW_BYTE        = pc_q[7:0];
    assign INSTR              = ins_q;
    assign INSTR_VALID        = iv_q;
    assign TBL_WR             = tw_q;
    assign TBL_WR_ADDR        = dst_q;
    assign TBL_WR_DATA        = tdat_q;
    assign TABLE_HIGH_HOLDING = thi_q;
endmodule

// ### pmt_top_asserts.sv
/*
 * pmt_top_asserts: port-level checks of the table-read and fetch unit.
 * assumes: bound to pmt_top; REF_CLK is the only clock.
 */
`timescale 1ns/1ps
module pmt_top_asserts (
    // clock and reset
    input wire logic       REF_CLK,
    input wire logic       RST_B,
    // cpu side
    input wire logic       TBL_RD_ANY,
    input wire logic       TBL_RD_PAGE,
    input wire logic [7:0] TBL_DEST,
    input wire logic [9:0] PC,
    input wire logic       INSTR_VALID,
    input wire logic [7:0] PC_LOW_BYTE,
    input wire logic       TBL_WR,
    input wire logic [7:0] TBL_WR_ADDR,
    input wire logic [7:0] TABLE_HIGH_HOLDING
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // ********************************
    // sequences
    // ********************************
    sequence two_fetch_s;
        INSTR_VALID ##1 INSTR_VALID;
    endsequence
    sequence tbl_req_s;
        $past(TBL_RD_ANY, 2) || $past(TBL_RD_PAGE, 2);
    endsequence
    // ********************************
    // assertions
    // ********************************
    tbl_pulse_a: assert property (TBL_WR |=> !TBL_WR) else $error("table write longer than one cycle");
    tbl_cause_a: assert property (TBL_WR |-> tbl_req_s) else $error("table write without strobe two cycles back");
    tbl_dest_a: assert property (TBL_WR |-> TBL_WR_ADDR == $past(TBL_DEST, 2)) else $error("wrong table dest");
    hold_zero_a: assert property (TABLE_HIGH_HOLDING[7:6] == 2'h0) else $error("holding top bits not zero");
    hold_change_a: assert property ($changed(TABLE_HIGH_HOLDING) |-> TBL_WR) else $error("holding moved alone");
    no_fetch_a: assert property (TBL_WR |-> !INSTR_VALID) else $error("fetch during table access");
    pc_mirror_a: assert property (PC_LOW_BYTE == PC[7:0]) else $error("pc low byte differs from pc");
    fetch_step_a: assert property (two_fetch_s |-> PC == $past(PC) + 10'h001) else $error("pc did not step");
endmodule

// ### pmt_prog_model.sv
/*
 * pmt_prog_model: serial programmer driving the clock and shared data line.
 * assumes: frames of cmd, address, data, msb first; 2 clk per clock phase.
 */
`timescale 1ns/1ps
module pmt_prog_model (
    // system clock for pacing
    input wire logic clk,
    // device side of the data line
    input wire logic dev_out,
    input wire logic dev_oe,
    // programmer lines
    output logic     sclk,
    output logic     line
);
    logic drv;
    // shared line, device drives when enabled
    assign line = dev_oe ? dev_out : drv;
    initial begin
        sclk = 1'b0;
        drv = 1'b0;
    end
    // programmer owns clock, idle low between frames
    task automatic frame(input logic [1:0] c, input logic [9:0] a, input logic [13:0] d, output logic [13:0] q);
        logic [25:0] f;
        f = {c, a, d};
        q = 14'h0000;
        for (int i = 25; i >= 0; i--) begin
            // released line toggles so a stale level cannot pass for data
            drv = (c == pmt_pkg::SER_CMD_RD && i < 14) ? ~drv : f[i];
            repeat (2) @(posedge clk);
            #1;
            if (c == pmt_pkg::SER_CMD_RD && i < 14) q[i] = line;
            sclk = 1'b1;
            repeat (2) @(posedge clk);
            #1 sclk = 1'b0;
        end
        repeat (3) @(posedge clk);
        #1;
    endtask
endmodule

// ### pmt_tb_top.sv
/*
 * pmt_tb_top: self-checking bench for pmt_top.
 * assumes: store contents survive reset; strobes driven 1 ns after edges.
 */
`timescale 1ns/1ps
module pmt_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, rd_any = 1'b0, rd_page = 1'b0, lo_wr = 1'b0, jump = 1'b0;
    logic [7:0]  dest = 8'h00, lo_d = 8'h00, pc_lo, wr_addr, wr_data, hold;
    logic [9:0]  ptr = 10'h000, jaddr = 10'h000, pc;
    logic [13:0] instr, q;
    logic        instr_valid, tbl_wr, sda_out, sda_oe, sclk, line;
    int          bad_count = 0, comparisons = 0;
    logic [9:0]  ad [5] = '{10'h000, 10'h300, 10'h305, 10'h306, 10'h3FF};
    logic [13:0] wd [5] = '{14'h2ABC, 14'h1234, 14'h000F, 14'h3A5C, 14'h15A3};
    always #10 clk = ~clk;
    pmt_top i_dut (.REF_CLK(clk), .RST_B(rst_b), .TBL_RD_ANY(rd_any), .TBL_RD_PAGE(rd_page), .TBL_DEST(dest),
        .TBL_PTR(ptr), .PC_LOW_WR(lo_wr), .PC_LOW_WDATA(lo_d), .JUMP(jump), .JUMP_ADDR(jaddr), .PC(pc),
        .INSTR(instr), .INSTR_VALID(instr_valid), .PC_LOW_BYTE(pc_lo), .TBL_WR(tbl_wr), .TBL_WR_ADDR(wr_addr),
        .TBL_WR_DATA(wr_data), .TABLE_HIGH_HOLDING(hold), .PROG_SERIAL_CLOCK_LINE(sclk),
        .PROG_SERIAL_DATA_LINE_IN(line), .PROG_SERIAL_DATA_LINE_OUT(sda_out), .PROG_SERIAL_DATA_LINE_OE(sda_oe));
    pmt_prog_model i_prog (.clk(clk), .dev_out(sda_out), .dev_oe(sda_oe), .sclk(sclk), .line(line));
    task automatic chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wait_valid;
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        #1;
        while (instr_valid !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        if (instr_valid !== 1'b1) begin
            bad_count++;
            results();
        end
    endtask
    task automatic reset_vector;
        #1 rst_b = 1'b0;
        #1 chk("pc in reset", pc, 14'h0000);
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        wait_valid();
        chk("first word", instr, wd[0]);
        chk("pc after first fetch", pc, 14'h0001);
    endtask
    task automatic table_any;
        ptr = 10'h306;
        dest = 8'h42;
        rd_any = 1'b1;
        // second strobe cycle falls in the table cycle and must be ignored
        repeat (2) @(posedge clk);
        #1 rd_any = 1'b0;
        chk("table write", tbl_wr, 14'h0001);
        chk("fetch held off", instr_valid, 14'h0000);
        chk("dest", wr_addr, 14'h0042);
        chk("low byte", wr_data, 14'h005C);
        chk("holding", hold, 14'h003A);
        @(posedge clk);
        #1 chk("refused strobe", tbl_wr, 14'h0000);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic page_and_low_byte;
        jaddr = 10'h300;
        jump = 1'b1;
        @(posedge clk);
        #1 jump = 1'b0;
        wait_valid();
        chk("jump word", instr, wd[1]);
        chk("jump pc", pc, 14'h0301);
        ptr = 10'h105;
        dest = 8'h11;
        rd_page = 1'b1;
        @(posedge clk);
        #1 rd_page = 1'b0;
        @(posedge clk);
        #1 chk("page low byte", wr_data, 14'h000F);
        chk("page holding", hold, 14'h0000);
        repeat (2) @(posedge clk);
        #1 lo_d = 8'h10;
        lo_wr = 1'b1;
        @(posedge clk);
        #1 lo_wr = 1'b0;
        wait_valid();
        chk("pc after low byte write", pc, 14'h0311);
        chk("pc low byte", pc_lo, 14'h0011);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < 5; i++) i_prog.frame(pmt_pkg::SER_CMD_WR, ad[i], wd[i], q);
        reset_vector();
        table_any();
        page_and_low_byte();
        for (int i = 0; i < 5; i++) begin
            i_prog.frame(pmt_pkg::SER_CMD_RD, ad[i], 14'h0000, q);
            chk("serial read", q, wd[i]);
        end
        results();
    end
endmodule
bind pmt_top pmt_top_asserts i_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .TBL_RD_ANY(TBL_RD_ANY),
    .TBL_RD_PAGE(TBL_RD_PAGE), .TBL_DEST(TBL_DEST), .PC(PC), .INSTR_VALID(INSTR_VALID), .PC_LOW_BYTE(PC_LOW_BYTE),
    .TBL_WR(TBL_WR), .TBL_WR_ADDR(TBL_WR_ADDR), .TABLE_HIGH_HOLDING(TABLE_HIGH_HOLDING));
